// >>> src/lalu_pkg.sv
package lalu_pkg;

localparam int DATA_W = 8;

// operation select codes driven by the decoder
typedef enum logic [3:0] {
    LALU_OP_NONE = 4'b0000,
    LALU_OP_AND = 4'b0001,
    LALU_OP_OR = 4'b0010,
    LALU_OP_XOR = 4'b0011,
    LALU_OP_ZERO = 4'b0100,
    LALU_OP_INV = 4'b0101,
    LALU_OP_RL = 4'b0110,
    LALU_OP_RLC = 4'b0111,
    LALU_OP_RR = 4'b1000,
    LALU_OP_RRC = 4'b1001,
    LALU_OP_SWAP = 4'b1010
} lalu_op_t;

// operand source / destination form
typedef enum logic [2:0] {
    LALU_SRC_BANK = 3'b000,
    LALU_SRC_DIRECT = 3'b001,
    LALU_SRC_POINTER = 3'b010,
    LALU_SRC_IMM = 3'b011,
    LALU_DST_DIRECT_ACC = 3'b100,
    LALU_DST_DIRECT_IMM = 3'b101
} lalu_form_t;

// cycle counts per form
localparam logic [1:0] CYC_BANK = 2'h1;
localparam logic [1:0] CYC_DIRECT = 2'h2;
localparam logic [1:0] CYC_POINTER = 2'h2;
localparam logic [1:0] CYC_IMM = 2'h2;
localparam logic [1:0] CYC_DST_ACC = 2'h3;
localparam logic [1:0] CYC_DST_IMM = 2'h3;
localparam logic [1:0] CYC_UNARY = 2'h1;

// instruction lengths in bytes per form
localparam logic [1:0] LEN_BANK = 2'h1;
localparam logic [1:0] LEN_DIRECT = 2'h2;
localparam logic [1:0] LEN_POINTER = 2'h1;
localparam logic [1:0] LEN_IMM = 2'h2;
localparam logic [1:0] LEN_DST_ACC = 2'h2;
localparam logic [1:0] LEN_DST_IMM = 2'h3;
localparam logic [1:0] LEN_UNARY = 2'h1;

localparam logic [7:0] ACC_RESET = 8'h00;
localparam logic CARRY_RESET = 1'b0;

endpackage

// >>> src/lalu_core.sv
`timescale 1ns/1ps

module lalu_core #(
    parameter int DATA_W = lalu_pkg::DATA_W
) (
    input wire logic ref_clk, // cpu clock
    input wire logic rst, // synchronous reset, active high
    input wire logic start, // one-cycle pulse: begin an instruction
    input wire lalu_pkg::lalu_op_t op, // operation select, sampled at start
    input wire lalu_pkg::lalu_form_t form, // operand form, sampled at start
    input wire logic [DATA_W-1:0] operand_a, // bank/direct/ram/immediate byte, at start
    input wire logic [DATA_W-1:0] operand_b, // immediate for direct-immediate form, at start
    output logic [DATA_W-1:0] acc, // accumulator
    output logic carry, // carry flag
    output logic busy, // instruction in progress
    output logic done, // one-cycle pulse at completion
    output logic [1:0] instr_len, // byte length of the finishing instruction
    output logic mem_we, // one-cycle pulse: write mem_wdata to direct byte
    output logic [DATA_W-1:0] mem_wdata // write-back data
);

////////////////////////////////////////////////////////////////////////////////

typedef enum logic [1:0] {
    LALU_IDLE = 2'b00,
    LALU_RUN = 2'b01
} lalu_state_t;

// sequencer state, counters and registered outputs
lalu_state_t state_reg, state_next;
logic [1:0] cnt_reg, cnt_next;
logic [DATA_W-1:0] acc_reg, acc_next;
logic carry_reg, carry_next;
logic [DATA_W-1:0] res_reg, res_next;
logic to_mem_reg, to_mem_next;
logic [1:0] len_reg, len_next;
logic done_reg, done_next;
logic we_reg, we_next;
logic [DATA_W-1:0] wdata_reg, wdata_next;

// combinational datapath terms
logic [DATA_W-1:0] lhs;
logic [DATA_W-1:0] rhs;
logic [DATA_W-1:0] result;
logic carry_res;
logic [1:0] cycles;
logic [1:0] length;
logic is_unary;

////////////////////////////////////////////////////////////////////////////////
// operand routing and datapath
// the result is formed once, from the accumulator, carry and operands that
// stand at the taking edge; multi-cycle forms park it in res_reg, so the
// decoder may change its operand lines while the instruction runs
// direct-immediate form: the direct byte comes on operand_a, the immediate
// on operand_b, and the accumulator takes no part
// each bitwise result bit depends only on the same bit of both operands

always_comb
begin
    is_unary = (op != lalu_pkg::LALU_OP_AND) && (op != lalu_pkg::LALU_OP_OR)
        && (op != lalu_pkg::LALU_OP_XOR);
    lhs = acc_reg;
    rhs = operand_a;
    if (form == lalu_pkg::LALU_DST_DIRECT_IMM)
    begin
        lhs = operand_a;
        rhs = operand_b;
    end
    result = acc_reg;
    carry_res = carry_reg;
    // ops outside the decoded set leave acc and carry as they are
    unique case (op)
        lalu_pkg::LALU_OP_AND: result = lhs & rhs;
        lalu_pkg::LALU_OP_OR: result = lhs | rhs;
        lalu_pkg::LALU_OP_XOR: result = lhs ^ rhs;
        lalu_pkg::LALU_OP_ZERO: result = '0;
        lalu_pkg::LALU_OP_INV: result = ~acc_reg;
        lalu_pkg::LALU_OP_RL: result = {acc_reg[DATA_W-2:0], acc_reg[DATA_W-1]};
        lalu_pkg::LALU_OP_RR: result = {acc_reg[0], acc_reg[DATA_W-1:1]};
        lalu_pkg::LALU_OP_RLC:
        begin
            result = {acc_reg[DATA_W-2:0], carry_reg};
            carry_res = acc_reg[DATA_W-1];
        end
        lalu_pkg::LALU_OP_RRC:
        begin
            result = {carry_reg, acc_reg[DATA_W-1:1]};
            carry_res = acc_reg[0];
        end
        lalu_pkg::LALU_OP_SWAP:
            result = {acc_reg[DATA_W/2-1:0], acc_reg[DATA_W-1:DATA_W/2]};
        default: result = acc_reg;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// cycle and length per form
// unary operations finish in one cycle whatever form code is presented, so a
// stale form left on the bus by the decoder cannot stretch them
// an unused form code on a binary operation is handled as the bank form,
// which keeps the sequencer from ever waiting on an undefined count

always_comb
begin
    cycles = lalu_pkg::CYC_UNARY;
    length = lalu_pkg::LEN_UNARY;
    if (!is_unary)
    begin
        unique case (form)
            lalu_pkg::LALU_SRC_BANK:
            begin
                cycles = lalu_pkg::CYC_BANK;
                length = lalu_pkg::LEN_BANK;
            end
            lalu_pkg::LALU_SRC_DIRECT:
            begin
                cycles = lalu_pkg::CYC_DIRECT;
                length = lalu_pkg::LEN_DIRECT;
            end
            lalu_pkg::LALU_SRC_POINTER:
            begin
                cycles = lalu_pkg::CYC_POINTER;
                length = lalu_pkg::LEN_POINTER;
            end
            lalu_pkg::LALU_SRC_IMM:
            begin
                cycles = lalu_pkg::CYC_IMM;
                length = lalu_pkg::LEN_IMM;
            end
            lalu_pkg::LALU_DST_DIRECT_ACC:
            begin
                cycles = lalu_pkg::CYC_DST_ACC;
                length = lalu_pkg::LEN_DST_ACC;
            end
            lalu_pkg::LALU_DST_DIRECT_IMM:
            begin
                cycles = lalu_pkg::CYC_DST_IMM;
                length = lalu_pkg::LEN_DST_IMM;
            end
            default:
            begin
                cycles = lalu_pkg::CYC_BANK;
                length = lalu_pkg::LEN_BANK;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// sequencer: result is computed at start and committed on the last cycle
// the count is loaded with cycles minus two: the taking edge and the
// committing edge each account for one cycle, the count covers the rest
// start is looked at only in idle; a start that arrives while an instruction
// runs is dropped, not queued, so the decoder must wait for done
// write-back forms leave the accumulator alone and pulse mem_we with done

always_comb
begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    acc_next = acc_reg;
    carry_next = carry_reg;
    res_next = res_reg;
    to_mem_next = to_mem_reg;
    len_next = len_reg;
    done_next = 1'b0;
    we_next = 1'b0;
    wdata_next = wdata_reg;
    unique case (state_reg)
        LALU_IDLE:
        begin
            if (start && op != lalu_pkg::LALU_OP_NONE)
            begin
                len_next = length;
                if (cycles == 2'h1)
                begin
                    acc_next = result;
                    // carry moves only for the through-carry rotates; for every
                    // other operation carry_res is simply carry_reg
                    carry_next = carry_res;
                    done_next = 1'b1;
                end
                else
                begin
                    res_next = result;
                    // the committed result goes either to the direct byte or to acc
                    to_mem_next = !is_unary && (form == lalu_pkg::LALU_DST_DIRECT_ACC
                        || form == lalu_pkg::LALU_DST_DIRECT_IMM);
                    cnt_next = cycles - 2'h2;
                    state_next = LALU_RUN;
                end
            end
        end
        LALU_RUN:
        begin
            if (cnt_reg == 2'h0)
            begin
                state_next = LALU_IDLE;
                done_next = 1'b1;
                if (to_mem_reg)
                begin
                    we_next = 1'b1;
                    wdata_next = res_reg;
                end
                else
                begin
                    acc_next = res_reg;
                end
            end
            else
            begin
                // three-cycle forms spend one extra run cycle here
                cnt_next = cnt_reg - 2'h1;
            end
        end
        default: state_next = LALU_IDLE;
    endcase
end

always_ff @(posedge ref_clk)
begin
    if (rst)
    begin
        // every register is cleared, so outputs show a known idle state
        // from the first cycle after release
        state_reg <= LALU_IDLE;
        cnt_reg <= 2'h0;
        acc_reg <= lalu_pkg::ACC_RESET;
        carry_reg <= lalu_pkg::CARRY_RESET;
        res_reg <= '0;
        to_mem_reg <= 1'b0;
        len_reg <= 2'h0;
        done_reg <= 1'b0;
        we_reg <= 1'b0;
        wdata_reg <= '0;
    end
    else
    begin
        state_reg <= state_next;
        cnt_reg <= cnt_next;
        acc_reg <= acc_next;
        carry_reg <= carry_next;
        res_reg <= res_next;
        to_mem_reg <= to_mem_next;
        len_reg <= len_next;
        done_reg <= done_next;
        we_reg <= we_next;
        wdata_reg <= wdata_next;
    end
end

////////////////////////////////////////////////////////////////////////////////

// busy follows the next state, so it rises in the first run cycle and is
// already low in the cycle that carries done
// it sits in its own register group to keep output decoding out of the
// sequencer's next-state logic
logic busy_reg;
logic busy_next;

always_comb
begin
    busy_next = (state_next == LALU_RUN);
end

always_ff @(posedge ref_clk)
begin
    if (rst)
    begin
        busy_reg <= 1'b0;
    end
    else
    begin
        busy_reg <= busy_next;
    end
end

// every output is a plain register copy; done and mem_we are one-cycle
// pulses, acc, carry, instr_len and mem_wdata hold until next written
assign acc = acc_reg;
assign carry = carry_reg;
assign busy = busy_reg;
assign done = done_reg;
assign instr_len = len_reg;
assign mem_we = we_reg;
assign mem_wdata = wdata_reg;

endmodule

// >>> tb/lalu_core_monitor.sv
`timescale 1ns/1ps
module lalu_core_monitor #(
    parameter int DATA_W = 8
) (
    input wire logic ref_clk, // clock
    input wire logic rst, // reset
    input wire logic start, // request
    input wire lalu_pkg::lalu_op_t op, // operation
    input wire lalu_pkg::lalu_form_t form, // form
    input wire logic [DATA_W-1:0] operand_a, // operand
    input wire logic [DATA_W-1:0] operand_b, // immediate
    input wire logic [DATA_W-1:0] acc, // accumulator
    input wire logic carry, // carry
    input wire logic busy, // busy
    input wire logic done, // done
    input wire logic [1:0] instr_len, // length
    input wire logic mem_we, // write pulse
    input wire logic [DATA_W-1:0] mem_wdata // write data
);
////////////////////////////////////////////////////////////////////////////////
function automatic logic [DATA_W-1:0] lop(lalu_pkg::lalu_op_t o, logic [DATA_W-1:0] x,
    logic [DATA_W-1:0] y);
    case (o)
        lalu_pkg::LALU_OP_AND: lop = x & y;
        lalu_pkg::LALU_OP_OR: lop = x | y;
        default: lop = x ^ y;
    endcase
endfunction
logic take;
logic bin;
assign take = start && !busy && op != lalu_pkg::LALU_OP_NONE;
assign bin = op inside {lalu_pkg::LALU_OP_AND, lalu_pkg::LALU_OP_OR, lalu_pkg::LALU_OP_XOR};
default clocking cb @(posedge ref_clk); endclocking
default disable iff (rst);
////////////////////////////////////////////////////////////////////////////////
bitwise_bank_a: assert property (take && bin && form == lalu_pkg::LALU_SRC_BANK |=>
    done && instr_len == 2'h1 && acc == lop($past(op), $past(acc), $past(operand_a)))
    else $error("bank form result or timing wrong");
direct_two_a: assert property (take && bin && form == lalu_pkg::LALU_SRC_DIRECT |=>
    busy && !done ##1 done && !busy && instr_len == 2'h2) else $error("direct form timing wrong");
pointer_two_a: assert property (take && bin && form == lalu_pkg::LALU_SRC_POINTER |=>
    !done ##1 done && instr_len == 2'h1) else $error("pointer form timing wrong");
imm_two_a: assert property (take && bin && form == lalu_pkg::LALU_SRC_IMM |=>
    !done ##1 done && instr_len == 2'h2) else $error("immediate form timing wrong");
dst_acc_a: assert property (take && bin && form == lalu_pkg::LALU_DST_DIRECT_ACC |=>
    (busy && !mem_we)[*2] ##1 mem_we && done && instr_len == 2'h2 && acc == $past(acc, 3)
    && mem_wdata == lop($past(op, 3), $past(acc, 3), $past(operand_a, 3)))
    else $error("accumulator into direct byte wrong");
dst_imm_a: assert property (take && bin && form == lalu_pkg::LALU_DST_DIRECT_IMM |=>
    !mem_we[*2] ##1 mem_we && instr_len == 2'h3
    && mem_wdata == lop($past(op, 3), $past(operand_a, 3), $past(operand_b, 3)))
    else $error("immediate into direct byte wrong");
rot_carry_a: assert property (take && op == lalu_pkg::LALU_OP_RLC |=>
    {carry, acc} == {$past(acc), $past(carry)}) else $error("left carry rotate wrong");
rot_rcarry_a: assert property (take && op == lalu_pkg::LALU_OP_RRC |=>
    {acc, carry} == {$past(carry), $past(acc)}) else $error("right carry rotate wrong");
swap_half_a: assert property (take && op == lalu_pkg::LALU_OP_SWAP |=>
    acc == {$past(acc[3:0]), $past(acc[7:4])} && done) else $error("nibble swap wrong");
plain_rot_a: assert property (take && (op == lalu_pkg::LALU_OP_RL
    || op == lalu_pkg::LALU_OP_RR) |=> $stable(carry) && done
    && acc == (($past(op) == lalu_pkg::LALU_OP_RL) ? {$past(acc[6:0]), $past(acc[7])}
    : {$past(acc[0]), $past(acc[7:1])})) else $error("plain rotate wrong");
clear_inv_a: assert property (take && (op == lalu_pkg::LALU_OP_ZERO
    || op == lalu_pkg::LALU_OP_INV) |=> done && instr_len == 2'h1
    && acc == (($past(op) == lalu_pkg::LALU_OP_ZERO) ? 8'h00 : ~$past(acc)))
    else $error("clear or complement wrong");
cover property (take && form == lalu_pkg::LALU_DST_DIRECT_IMM);
cover property (start && busy);
cover property (take && op == lalu_pkg::LALU_OP_RRC);
endmodule

// >>> tb/lalu_mem_model.sv
`timescale 1ns/1ps
// direct byte store that takes the block's write-backs
module lalu_mem_model (
    input wire logic ref_clk, // clock
    input wire logic rst, // reset
    input wire logic mem_we, // write pulse
    input wire logic [7:0] mem_wdata, // write data
    output logic [7:0] mem_byte // stored byte
);
always_ff @(posedge ref_clk)
begin
    if (rst)
        mem_byte <= 8'h00;
    else if (mem_we)
        mem_byte <= mem_wdata;
end
endmodule

// >>> tb/tb_logical_instruction_alu.sv
`timescale 1ns/1ps
module tb_logical_instruction_alu;
logic ref_clk = 1'b0, rst = 1'b1, start = 1'b0, carry, busy, done, mem_we;
lalu_pkg::lalu_op_t op = lalu_pkg::LALU_OP_NONE;
lalu_pkg::lalu_form_t form = lalu_pkg::LALU_SRC_BANK;
logic [7:0] operand_a = 8'h00, operand_b = 8'h00, acc, mem_wdata, mem_byte;
logic [1:0] instr_len;
int n_mismatch = 0, compares = 0;
lalu_core dut_u (.ref_clk(ref_clk), .rst(rst), .start(start), .op(op), .form(form),
    .operand_a(operand_a), .operand_b(operand_b), .acc(acc), .carry(carry), .busy(busy),
    .done(done), .instr_len(instr_len), .mem_we(mem_we), .mem_wdata(mem_wdata));
lalu_mem_model mem_u (.ref_clk(ref_clk), .rst(rst), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .mem_byte(mem_byte));
initial
begin
    forever #20 ref_clk = ~ref_clk;
end
////////////////////////////////////////////////////////////////////////////////
task give_verdict;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask
task chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e)
    begin
        n_mismatch++;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
endtask
// one instruction; returns at the falling edge inside the done cycle
task automatic iss(input lalu_pkg::lalu_op_t o, input lalu_pkg::lalu_form_t f,
    input logic [7:0] a, input logic [7:0] b, input int cyc, input logic [1:0] len,
    input logic [7:0] ea);
    int n;
    @(negedge ref_clk);
    start = 1'b1;
    op = o;
    form = f;
    operand_a = a;
    operand_b = b;
    @(negedge ref_clk);
    start = 1'b0;
    n = 1;
    while (done !== 1'b1)
    begin
        if (n == 8)
        begin
            n_mismatch++;
            give_verdict;
        end
        @(negedge ref_clk);
        n++;
    end
    chk(8'(n), 8'(cyc));
    chk({6'h00, instr_len}, {6'h00, len});
    chk(acc, ea);
endtask
////////////////////////////////////////////////////////////////////////////////
task t_bank;
    iss(lalu_pkg::LALU_OP_ZERO, lalu_pkg::LALU_SRC_BANK, 8'h00, 8'h00, 1, 2'h1, 8'h00);
    iss(lalu_pkg::LALU_OP_OR, lalu_pkg::LALU_SRC_BANK, 8'h5a, 8'h00, 1, 2'h1, 8'h5a);
    iss(lalu_pkg::LALU_OP_XOR, lalu_pkg::LALU_SRC_BANK, 8'hff, 8'h00, 1, 2'h1, 8'ha5);
    iss(lalu_pkg::LALU_OP_AND, lalu_pkg::LALU_SRC_BANK, 8'h3c, 8'h00, 1, 2'h1, 8'h24);
endtask
task t_forms;
    iss(lalu_pkg::LALU_OP_OR, lalu_pkg::LALU_SRC_DIRECT, 8'h42, 8'h00, 2, 2'h2, 8'h66);
    iss(lalu_pkg::LALU_OP_AND, lalu_pkg::LALU_SRC_POINTER, 8'h0f, 8'h00, 2, 2'h1, 8'h06);
    iss(lalu_pkg::LALU_OP_XOR, lalu_pkg::LALU_SRC_IMM, 8'hf0, 8'h00, 2, 2'h2, 8'hf6);
endtask
task t_dst;
    iss(lalu_pkg::LALU_OP_AND, lalu_pkg::LALU_DST_DIRECT_ACC, 8'h3c, 8'h00, 3, 2'h2,
        8'hf6);
    chk(mem_wdata, 8'h34);
    iss(lalu_pkg::LALU_OP_XOR, lalu_pkg::LALU_DST_DIRECT_IMM, 8'h55, 8'h0f, 3, 2'h3,
        8'hf6);
    @(negedge ref_clk);
    chk(mem_byte, 8'h5a);
endtask
task automatic t_rot;
    lalu_pkg::lalu_op_t ops[6] = '{lalu_pkg::LALU_OP_RLC, lalu_pkg::LALU_OP_RL,
        lalu_pkg::LALU_OP_RR, lalu_pkg::LALU_OP_RRC, lalu_pkg::LALU_OP_SWAP,
        lalu_pkg::LALU_OP_INV};
    logic [7:0] ea[6] = '{8'hec, 8'hd9, 8'hec, 8'hf6, 8'h6f, 8'h90};
    logic ec[6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < 6; i++)
    begin
        iss(ops[i], lalu_pkg::LALU_SRC_DIRECT, 8'h00, 8'h00, 1, 2'h1, ea[i]);
        chk({7'h00, carry}, {7'h00, ec[i]});
    end
endtask
// start held through busy is ignored, as is an empty operation
task t_refuse;
    @(negedge ref_clk);
    start = 1'b1;
    op = lalu_pkg::LALU_OP_XOR;
    form = lalu_pkg::LALU_SRC_DIRECT;
    operand_a = 8'hff;
    @(negedge ref_clk);
    op = lalu_pkg::LALU_OP_ZERO;
    @(negedge ref_clk);
    chk({7'h00, done}, 8'h01);
    start = 1'b0;
    chk(acc, 8'h6f);
    @(negedge ref_clk);
    start = 1'b1;
    op = lalu_pkg::LALU_OP_NONE;
    @(negedge ref_clk);
    start = 1'b0;
    chk({done, busy, 6'h00}, 8'h00);
    chk(acc, 8'h6f);
endtask
// a reset while no instruction runs returns every output to its idle value
task t_reset;
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    chk(acc, 8'h00);
    chk(mem_wdata, 8'h00);
    chk({carry, busy, done, mem_we, instr_len, 2'h0}, 8'h00);
endtask
// plain rotates where the carry differs from the bit that wraps, then a clear
task t_plain;
    iss(lalu_pkg::LALU_OP_OR, lalu_pkg::LALU_SRC_BANK, 8'h6f, 8'h00, 1, 2'h1, 8'h6f);
    iss(lalu_pkg::LALU_OP_RR, lalu_pkg::LALU_SRC_BANK, 8'h00, 8'h00, 1, 2'h1, 8'hb7);
    chk({7'h00, carry}, 8'h00);
    iss(lalu_pkg::LALU_OP_RL, lalu_pkg::LALU_SRC_BANK, 8'h00, 8'h00, 1, 2'h1, 8'h6f);
    chk({7'h00, carry}, 8'h00);
    iss(lalu_pkg::LALU_OP_ZERO, lalu_pkg::LALU_SRC_BANK, 8'hff, 8'h00, 1, 2'h1, 8'h00);
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    chk(acc, 8'h00);
    chk({carry, busy, done, mem_we, instr_len, 2'h0}, 8'h00);
    t_bank;
    t_forms;
    t_dst;
    t_rot;
    t_refuse;
    t_reset;
    t_plain;
    give_verdict;
end
endmodule
bind lalu_core lalu_core_monitor #(.DATA_W(DATA_W)) mon_u (.ref_clk(ref_clk), .rst(rst),
    .start(start), .op(op), .form(form), .operand_a(operand_a), .operand_b(operand_b),
    .acc(acc), .carry(carry), .busy(busy), .done(done), .instr_len(instr_len),
    .mem_we(mem_we), .mem_wdata(mem_wdata));
